// ===== hdl/peewp_defs.vh
`ifndef PEEWP_DEFS_VH
`define PEEWP_DEFS_VH
// pin widths, low address width and bytes per page
`define PEEWP_ADDR_W      13
`define PEEWP_DATA_W      8
`define PEEWP_LOW_AW      4
`define PEEWP_PAGE_MAX    5'h10
// clock rate in MHz
`define PEEWP_CLK_MHZ     100
// strobe timing in ns
`define PEEWP_T_WP_NS     150
`define PEEWP_T_WPH_NS    50
`define PEEWP_T_AS_NS     10
`define PEEWP_T_DH_NS     20
`define PEEWP_T_OE_NS     150
// byte load interval, longest, in us
`define PEEWP_T_BLC_US    20
// cycles kept in hand for strobe, recovery and set-up before the next fall
`define PEEWP_BLC_MARGIN  24'h000020
// programming time, longest, in ms
`define PEEWP_T_WC_MS     10
// top data bit position
`define PEEWP_TOP_BIT     7
`endif

// ===== hdl/peewp_timer.v
`timescale 1ns/1ns
// down counter: load a count, done pulses when it expires
module peewp_timer #(
  parameter W = 24
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         load,
  input  wire [W-1:0] count,
  output wire         busy,
  output reg          done_ff
);
  reg [W-1:0] cnt_ff;

  // a load always restarts the count
  always @(posedge clk) begin
    if (rst) begin
      cnt_ff  <= {W{1'b0}};
      done_ff <= 1'b0;
    end else if (load) begin
      cnt_ff  <= count;
      done_ff <= 1'b0;
    end else begin
      done_ff <= (cnt_ff == {{(W-1){1'b0}}, 1'b1});
      if (cnt_ff != {W{1'b0}})
        cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign busy = (cnt_ff != {W{1'b0}});
endmodule

// ===== hdl/peewp_host.v
`timescale 1ns/1ns
`include "peewp_defs.vh"
// Summary of operation
// - select low for every access, else standby
// - write strobe: select, strobe low, gate high
// - page address bits fixed during a page
// - extra page bytes use the same cycle
// - next load within twenty us of previous
// - inhibit state held outside writes
module peewp_host #(
  parameter WC_CYC = `PEEWP_T_WC_MS * 1000 * 1000 / (1000 / `PEEWP_CLK_MHZ)
) (
  input  wire                       clk,
  input  wire                       rst,
  input  wire                       cmd_valid,
  input  wire                       cmd_write,
  input  wire                       cmd_last,
  input  wire [`PEEWP_ADDR_W-1:0]   cmd_addr,
  input  wire [`PEEWP_DATA_W-1:0]   cmd_wdata,
  output reg                        cmd_ready_ff,
  output reg                        rsp_valid_ff,
  output reg  [`PEEWP_DATA_W-1:0]   rsp_rdata_ff,
  output reg                        rsp_timeout_ff,
  output reg                        chip_select_n_ff,
  output reg                        output_gate_n_ff,
  output reg                        write_strobe_n_ff,
  output reg  [`PEEWP_ADDR_W-1:0]   addr_ff,
  output reg  [`PEEWP_DATA_W-1:0]   data_out_ff,
  output reg                        data_oe_ff,
  input  wire [`PEEWP_DATA_W-1:0]   data_in
);
  localparam CYC_NS   = 1000 / `PEEWP_CLK_MHZ;
  localparam WP_CYC   = (`PEEWP_T_WP_NS + CYC_NS - 1) / CYC_NS;
  localparam WPH_CYC  = (`PEEWP_T_WPH_NS + CYC_NS - 1) / CYC_NS;
  localparam AS_CYC   = (`PEEWP_T_AS_NS + CYC_NS - 1) / CYC_NS;
  localparam DH_CYC   = (`PEEWP_T_DH_NS + CYC_NS - 1) / CYC_NS;
  localparam OE_CYC   = (`PEEWP_T_OE_NS + CYC_NS - 1) / CYC_NS + 1;
  localparam BLC_CYC  = `PEEWP_T_BLC_US * 1000 / CYC_NS;
  localparam TW       = 24;

  localparam S_IDLE  = 4'h0;
  localparam S_WSET  = 4'h1;
  localparam S_WLOW  = 4'h2;
  localparam S_WHOLD = 4'h3;
  localparam S_PAGE  = 4'h4;
  localparam S_RSET  = 4'h5;
  localparam S_RACC  = 4'h6;
  localparam S_POLL  = 4'h7;
  localparam S_PACC  = 4'h8;
  localparam S_PREC  = 4'h9;

  reg  [3:0]               state_ff;
  reg  [`PEEWP_ADDR_W-1:0] page_ff;       // page of the open page write
  reg  [4:0]               nbytes_ff;     // bytes loaded in this page
  reg  [`PEEWP_DATA_W-1:0] last_data_ff;  // last byte written, for polling
  reg  [`PEEWP_DATA_W-1:0] sync1_ff;
  reg  [`PEEWP_DATA_W-1:0] sync2_ff;
  reg                      t_load;
  reg  [TW-1:0]            t_count;
  wire                     t_busy;
  wire                     t_done;
  reg                      w_load;
  wire                     w_busy;
  wire                     w_done;

  // phase timer for strobe widths and read access
  peewp_timer #(.W(TW)) u_phase (
    .clk     (clk),
    .rst     (rst),
    .load    (t_load),
    .count   (t_count),
    .busy    (t_busy),
    .done_ff ()
  );

  // programming-time ceiling, gives up polling once it runs out
  peewp_timer #(.W(TW)) u_wc (
    .clk     (clk),
    .rst     (rst),
    .load    (w_load),
    .count   (WC_CYC[TW-1:0]),
    .busy    (w_busy),
    .done_ff (w_done)
  );

  // pin data passes two flops before use
  always @(posedge clk) begin
    if (rst) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
    end else begin
      sync1_ff <= data_in;
      sync2_ff <= sync1_ff;
    end
  end

  // timer loads chosen by the sequencer
  always @* begin
    t_load  = 1'b0;
    t_count = {TW{1'b0}};
    w_load  = 1'b0;
    case (state_ff)
      S_IDLE: begin
        if (cmd_valid) begin
          t_load  = 1'b1;
          t_count = AS_CYC[TW-1:0];
        end
      end
      S_WSET: begin
        if (!t_busy) begin
          t_load  = 1'b1;
          t_count = WP_CYC[TW-1:0];
        end
      end
      S_WLOW: begin
        if (!t_busy) begin
          t_load  = 1'b1;
          t_count = DH_CYC[TW-1:0] > WPH_CYC[TW-1:0] ? DH_CYC[TW-1:0] : WPH_CYC[TW-1:0];
        end
      end
      S_WHOLD: begin
        if (!t_busy) begin
          t_load  = 1'b1;
          // the window counts from the falling strobe, so the low and high
          // phases and the next set-up come off it, with margin to spare
          t_count = BLC_CYC[TW-1:0] - WP_CYC[TW-1:0] - WPH_CYC[TW-1:0] -
                    `PEEWP_BLC_MARGIN;
        end
      end
      S_PAGE: begin
        // must mirror the sequencer: a same-page write flagged last also closes
        if (!(cmd_valid && cmd_write && !cmd_last &&
            cmd_addr[`PEEWP_ADDR_W-1:`PEEWP_LOW_AW] ==
            page_ff[`PEEWP_ADDR_W-1:`PEEWP_LOW_AW] && nbytes_ff < `PEEWP_PAGE_MAX) &&
            (cmd_last || !t_busy || cmd_valid))
          w_load = 1'b1;              // page closes, device starts programming
        if (cmd_valid && !cmd_last) begin
          t_load  = 1'b1;
          t_count = AS_CYC[TW-1:0];
        end
      end
      S_RSET, S_PREC: begin
        t_load  = 1'b1;
        t_count = OE_CYC[TW-1:0] + 24'h000002;
      end
      default: begin
        t_load  = 1'b0;
      end
    endcase
  end

  // main sequencer
  always @(posedge clk) begin
    if (rst) begin
      state_ff          <= S_IDLE;
      cmd_ready_ff      <= 1'b0;
      rsp_valid_ff      <= 1'b0;
      rsp_rdata_ff      <= 8'h00;
      rsp_timeout_ff    <= 1'b0;
      chip_select_n_ff  <= 1'b1;
      output_gate_n_ff  <= 1'b1;
      write_strobe_n_ff <= 1'b1;
      addr_ff           <= 13'h0000;
      data_out_ff       <= 8'h00;
      data_oe_ff        <= 1'b0;
      page_ff           <= 13'h0000;
      nbytes_ff         <= 5'h00;
      last_data_ff      <= 8'h00;
    end else begin
      cmd_ready_ff   <= 1'b0;
      rsp_valid_ff   <= 1'b0;
      rsp_timeout_ff <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          if (cmd_valid) begin
            cmd_ready_ff     <= 1'b1;
            addr_ff          <= cmd_addr;
            chip_select_n_ff <= 1'b0;
            if (cmd_write) begin
              data_out_ff  <= cmd_wdata;
              data_oe_ff   <= 1'b1;
              page_ff      <= cmd_addr;
              nbytes_ff    <= 5'h00;
              state_ff     <= S_WSET;
            end else begin
              output_gate_n_ff <= 1'b0;
              state_ff         <= S_RSET;
            end
          end
        end
        S_WSET: begin
          if (!t_busy) begin
            write_strobe_n_ff <= 1'b0;
            state_ff          <= S_WLOW;
          end
        end
        S_WLOW: begin
          if (!t_busy) begin
            write_strobe_n_ff <= 1'b1;      // data latched on this rise
            nbytes_ff         <= nbytes_ff + 5'h01;
            last_data_ff      <= data_out_ff;
            state_ff          <= S_WHOLD;
          end
        end
        S_WHOLD: begin
          if (!t_busy) begin
            chip_select_n_ff <= 1'b1;
            data_oe_ff       <= 1'b0;
            state_ff         <= S_PAGE;
          end
        end
        S_PAGE: begin
          if (cmd_valid && cmd_write && !cmd_last && nbytes_ff < `PEEWP_PAGE_MAX &&
              cmd_addr[`PEEWP_ADDR_W-1:`PEEWP_LOW_AW] ==
              page_ff[`PEEWP_ADDR_W-1:`PEEWP_LOW_AW]) begin
            cmd_ready_ff     <= 1'b1;
            addr_ff          <= cmd_addr;
            data_out_ff      <= cmd_wdata;
            data_oe_ff       <= 1'b1;
            chip_select_n_ff <= 1'b0;
            state_ff         <= S_WSET;
          end else if (cmd_last || !t_busy || cmd_valid) begin
            addr_ff  <= addr_ff;            // poll the last byte written
            state_ff <= S_PREC;
          end
        end
        S_RSET: begin
          state_ff <= S_RACC;
        end
        S_RACC: begin
          if (!t_busy) begin
            rsp_valid_ff     <= 1'b1;
            rsp_rdata_ff     <= sync2_ff;
            chip_select_n_ff <= 1'b1;
            output_gate_n_ff <= 1'b1;
            state_ff         <= S_IDLE;
          end
        end
        S_PREC: begin
          chip_select_n_ff <= 1'b0;
          output_gate_n_ff <= 1'b0;
          state_ff         <= S_PACC;
        end
        S_PACC: begin
          if (!t_busy) begin
            chip_select_n_ff <= 1'b1;
            output_gate_n_ff <= 1'b1;
            if (sync2_ff[`PEEWP_TOP_BIT] == last_data_ff[`PEEWP_TOP_BIT]) begin
              rsp_valid_ff <= 1'b1;
              rsp_rdata_ff <= sync2_ff;
              state_ff     <= S_IDLE;
            end else if (!w_busy || w_done) begin
              rsp_valid_ff   <= 1'b1;
              rsp_timeout_ff <= 1'b1;
              rsp_rdata_ff   <= sync2_ff;
              state_ff       <= S_IDLE;
            end else begin
              state_ff <= S_POLL;           // inverted bit: still busy
            end
          end
        end
        S_POLL: begin
          state_ff <= S_PREC;               // two deselected cycles between polls, here and in S_PREC
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== tb/peewp_dev.sv
`timescale 1ns/1ns
// device: page buffer, own programming timer, polled status
module peewp_dev #(parameter PROG_NS = 5000) (
  input  wire        clk,
  input  wire        cs_n,
  input  wire        oe_n,
  input  wire        we_n,
  input  wire [12:0] a,
  input  wire [7:0]  d,
  output wire [7:0]  q
);
  reg [7:0]  mem [0:8191];
  reg [7:0]  pd [0:15];
  reg [15:0] pv = 0;
  reg [12:0] la = 0;
  reg        arm = 0, ld = 0, pg = 0, fl = 0;
  time       tf = 0, tp = 0;
  integer    i;
  wire [7:0] lb = pd[la[3:0]];
  // address at the later fall
  always @(negedge we_n or negedge cs_n)
    if (!cs_n && !we_n && oe_n && !pg) begin
      la = a;
      arm = 1;
      tf = $time;
    end
  // data at the earlier rise; glitches load nothing
  always @(posedge we_n or posedge cs_n)
    if (arm) begin
      arm = 0;
      if ($time - tf >= 20) begin
        pd[la[3:0]] = d;
        pv[la[3:0]] = 1;
        ld = 1;
      end
    end
  // silence closes the page, programming then runs alone
  always @(posedge clk) begin
    fl <= ~fl;
    if (ld && !arm && $time - tf > 20000) begin
      ld <= 0;
      pg <= 1;
      tp <= $time;
    end
    if (pg && $time - tp >= PROG_NS) begin
      for (i = 0; i < 16; i = i + 1)
        if (pv[i]) mem[{la[12:4], i[3:0]}] <= pd[i];
      pv <= 0;
      pg <= 0;
    end
  end
  // released bus toggles, there is no pull-up to lean on
  assign q = (cs_n || oe_n) ? {8{fl}} ^ 8'h5a :
    ((ld || pg) && a == la) ? {~lb[7], lb[6:0]} : mem[a];
endmodule

// ===== tb/peewp_host_asserts.sv
`timescale 1ns/1ns
// pin discipline of the controller
module peewp_host_chk (
  input wire        clk,
  input wire        rst,
  input wire        rsp_valid_ff,
  input wire        chip_select_n_ff,
  input wire        output_gate_n_ff,
  input wire        write_strobe_n_ff,
  input wire [12:0] addr_ff,
  input wire [7:0]  data_out_ff,
  input wire        data_oe_ff
);
  wire       we = write_strobe_n_ff;
  reg [11:0] gap_ff;
  reg [4:0]  low_ff;
  reg [8:0]  pg_ff;
  reg        pend_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // strobe low time, cycles since a load, open page, write in flight
  always @(posedge clk) begin
    low_ff <= we ? 5'h00 : low_ff + {4'h0, ~&low_ff};
    gap_ff <= rst ? 12'hfff : $fell(we) ? 12'h000 : gap_ff + {11'h0, ~&gap_ff};
    pg_ff <= $fell(we) ? addr_ff[12:4] : pg_ff;
    pend_ff <= !rst && ($fell(we) || pend_ff && !rsp_valid_ff);
  end
  property p_rd;
    !output_gate_n_ff |-> !chip_select_n_ff && !data_oe_ff;
  endproperty
  a_rd: assert property (p_rd) else $error("gate low unselected");
  property p_wr;
    !we |-> output_gate_n_ff && !chip_select_n_ff && data_oe_ff;
  endproperty
  a_wr: assert property (p_wr) else $error("strobe outside write");
  property p_wp;
    $rose(we) |-> low_ff >= 5'd15;
  endproperty
  a_wp: assert property (p_wp) else $error("strobe too short");
  property p_wph;
    $rose(we) |-> we [*5];
  endproperty
  a_wph: assert property (p_wph) else $error("recovery too short");
  property p_hold;
    !we |=> $stable(addr_ff) && $stable(data_out_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("bus moved in strobe");
  property p_page;
    $fell(we) && gap_ff < 12'd2000 |-> addr_ff[12:4] == pg_ff;
  endproperty
  a_page: assert property (p_page) else $error("page changed");
  property p_gap;
    $fell(we) && pend_ff |-> gap_ff < 12'd2000;
  endproperty
  a_gap: assert property (p_gap) else $error("late load");
endmodule
bind peewp_host peewp_host_chk peewp_host_chk_inst (.clk(clk), .rst(rst),
  .rsp_valid_ff(rsp_valid_ff), .chip_select_n_ff(chip_select_n_ff),
  .output_gate_n_ff(output_gate_n_ff), .write_strobe_n_ff(write_strobe_n_ff),
  .addr_ff(addr_ff), .data_out_ff(data_out_ff), .data_oe_ff(data_oe_ff));

// ===== tb/tb_peewp_host.sv
`timescale 1ns/1ns
// random pages with corner closes against the device model
module tb_peewp_host;
  reg         clk = 0, rst = 1, cv = 0, cw = 0, cl = 0;
  reg  [12:0] ca = 0, pa;
  reg  [7:0]  cd = 0, ld;
  reg  [7:0]  me [0:8191];
  reg  [8:0]  rq [$];
  wire        rdy, rv, rto, cs_n, oe_n, we_n, doe;
  wire [12:0] a;
  wire [7:0]  q, dout, rd;
  integer     seed = 32'h386d523c, fail_count = 0, n_compared = 0, cyc = 0, i, r;
  initial forever #5 clk = ~clk;
  peewp_host #(.WC_CYC(5000)) peewp_host_inst (.clk(clk), .rst(rst), .cmd_valid(cv),
    .cmd_write(cw), .cmd_last(cl), .cmd_addr(ca), .cmd_wdata(cd), .cmd_ready_ff(rdy),
    .rsp_valid_ff(rv), .rsp_rdata_ff(rd), .rsp_timeout_ff(rto), .chip_select_n_ff(cs_n),
    .output_gate_n_ff(oe_n), .write_strobe_n_ff(we_n), .addr_ff(a), .data_out_ff(dout),
    .data_oe_ff(doe), .data_in(doe ? dout : q));
  peewp_dev peewp_dev_inst (.clk(clk), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .a(a),
    .d(dout), .q(q));
  task report_and_stop;
    begin
      if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // one command, held until ready is seen at an edge
  task cmd(input w, input [12:0] ad, input [7:0] wd);
    begin
      @(posedge clk) #1;
      {cv, cw, ca, cd} = {1'b1, w, ad, wd};
      do begin
        @(posedge clk);
        #1;
      end while (rdy !== 1'b1);
      cv = 0;
    end
  endtask
  // random byte into the shadow copy, then onto the pins
  task wr(input [12:0] ad);
    begin
      r = $random(seed);
      ld = r[7:0];
      me[ad] = ld;
      cmd(1, ad, ld);
    end
  endtask
  // oldest response against the expected byte, timeout flag low
  task take(input [7:0] e);
    begin
      while (rq.size() == 0) @(posedge clk);
      n_compared = n_compared + 1;
      if (rq[0] !== {1'b0, e}) begin
        fail_count = fail_count + 1;
        $display("wrong value rsp_timeout_ff,rsp_rdata_ff expected %h seen %h", e, rq[0]);
      end
      rq.delete(0);
    end
  endtask
  // collect response pulses mid-cycle, where they have settled; cut a hang short
  always @(negedge clk) begin
    cyc = cyc + 1;
    if (rv === 1'b1) rq.push_back({rto, rd});
    if (cyc == 40000) begin
      fail_count = fail_count + 1;
      report_and_stop;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 0;
    r = $random(seed);
    pa = r[12:0];
    // full page, scrambled low nibble, closes when the window runs out after the sixteenth load
    for (i = 0; i < 16; i = i + 1) wr({pa[12:4], i[3:0] ^ pa[3:0]});
    take(ld);
    // two loads cut short by a read of another page
    wr(pa ^ 13'h0010);
    wr(pa ^ 13'h0011);
    cmd(0, pa, 8'h00);
    take(ld);
    take(me[pa]);
    // three loads closed at once by the last flag alone
    for (i = 0; i < 3; i = i + 1) wr({~pa[12], pa[11:4], i[3:0]});
    @(posedge clk) #1 cl = 1;
    take(ld);
    #1 cl = 0;
    // lone byte closed by silence, then the first page read back
    r = $random(seed);
    wr(r[12:0]);
    take(ld);
    for (i = 0; i < 16; i = i + 1) begin
      cmd(0, {pa[12:4], i[3:0]}, 8'h00);
      take(me[{pa[12:4], i[3:0]}]);
    end
    report_and_stop;
  end
endmodule
